// ### verilog/frame_buffer_hard_fill.sv
// Summary of operation
// - The fill command register at index 1ffff reads busy in bit 0, set by the automatic fill after reset.
// - Any write to the fill command register starts one fill, whatever the data.
// - A fill writes the palette colour of the stored index to every word of the chosen page.
// - Busy reads 1 right after a fill is accepted and 0 once the page is written.
// - A finished fill drives an active-low pulse on the completion output.
// - The completion pulse lasts about one line period, 66.5 us.
// - A fill starts by itself shortly after reset release, with busy set.
// - Fill page value 0 selects page 0, 1 selects page 1, 2 and 3 are inactive.
// - The fill value register at index 1fffe is write-only, reset zero, mode 7:6, index 5:0.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "fill_defines.svh"
module frame_buffer_hard_fill
  import fill_pkg::*;
#(
  parameter int FB_WORDS = `FB_WORDS_DEF
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [`APB_ADDR_W-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  output logic [5:0]                 palette_index,
  input  wire logic [`COLOR_W-1:0]   palette_color,
  output logic                       fb_we,
  output logic [`FB_AW-1:0]          fb_addr,
  output logic                       fb_page,
  output logic [`COLOR_W-1:0]        fb_data,
  output logic [1:0]                 color_mode,
  output logic                       fill_busy,
  output logic                       fill_done_n
);

  // Index decode of an aligned word address
  function automatic logic hit(input logic [`APB_ADDR_W-1:0] a, input logic [16:0] idx);
    hit = (a[`APB_ADDR_W-1:2] == idx) && (a[1:0] == 2'h0);
  endfunction

  fill_evt_if evt ();

  fill_done_pulse fill_done_pulse_inst (
    .pclk    (pclk),
    .presetn (presetn),
    .evt     (evt)
  );

  logic [7:0]         fill_value_reg;
  logic [7:0]         next_fill_value_reg;
  logic [7:0]         page_control_reg;
  logic [7:0]         next_page_control_reg;
  logic [31:0]        next_prdata;
  logic               mapped;
  logic               wr_access;
  logic               cmd_write;

  // ==========================================================================
  // APB slave: zero wait states, error on unmapped words
  assign mapped    = hit(paddr, `FILL_CMD_IDX) | hit(paddr, `FILL_VALUE_IDX)
                   | hit(paddr, `PAGE_CTRL_IDX);
  assign pready    = 1'b1;
  assign pslverr   = psel & penable & ~mapped;
  assign wr_access = psel & penable & pwrite & mapped;
  assign cmd_write = wr_access & hit(paddr, `FILL_CMD_IDX);

  // Register writes in the access cycle, read data captured in the setup cycle
  always_comb begin
    next_fill_value_reg   = fill_value_reg;
    next_page_control_reg = page_control_reg;
    next_prdata           = prdata;
    if (wr_access && pstrb[0]) begin
      if (hit(paddr, `FILL_VALUE_IDX)) begin
        next_fill_value_reg = pwdata[7:0];
      end
      if (hit(paddr, `PAGE_CTRL_IDX)) begin
        next_page_control_reg = pwdata[7:0];
      end
    end
    if (psel && !penable && !pwrite) begin
      next_prdata = '0; // Write-only registers read zero
      if (hit(paddr, `FILL_CMD_IDX)) begin
        next_prdata[`BUSY_BIT] = fill_busy;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fill_value_reg   <= `REG8_RESET;
      page_control_reg <= `REG8_RESET;
      prdata           <= '0;
    end else begin
      fill_value_reg   <= next_fill_value_reg;
      page_control_reg <= next_page_control_reg;
      prdata           <= next_prdata;
    end
  end

  // ==========================================================================
  // Fill engine
  fill_state_t       state;
  fill_state_t       next_state;
  logic [`FB_AW-1:0] count;
  logic [`FB_AW-1:0] next_count;
  logic              auto_pending;
  logic              next_auto_pending;
  logic              page_ok;
  logic              next_page_ok;
  logic              next_fb_page;
  logic              next_fb_we;
  logic [`FB_AW-1:0] next_fb_addr;
  logic [`COLOR_W-1:0] next_fb_data;
  logic [5:0]        next_palette_index;
  logic [1:0]        next_color_mode;
  logic              start;
  logic [1:0]        fill_page_select;

  localparam logic [`FB_AW-1:0] LAST_WORD = `FB_AW'(FB_WORDS - 1);

  assign start = cmd_write | auto_pending;
  assign fill_page_select = page_control_reg[`FILL_PAGE_HI:`FILL_PAGE_LO];

  always_comb begin
    next_state         = state;
    next_count         = count;
    next_auto_pending  = 1'b0;
    next_page_ok       = page_ok;
    next_fb_page       = fb_page;
    next_fb_we         = 1'b0;
    next_fb_addr       = fb_addr;
    next_fb_data       = fb_data;
    next_palette_index = palette_index;
    next_color_mode    = color_mode;
    evt.done_evt       = 1'b0;
    if (start) begin
      // A command during a fill restarts it with the new settings
      next_state         = ST_LOOKUP;
      next_count         = '0;
      next_palette_index = fill_value_reg[`INDEX_HI:`INDEX_LO];
      next_color_mode    = fill_value_reg[`MODE_HI:`MODE_LO];
      next_page_ok       = (fill_page_select == `PAGE_0)
                         || (fill_page_select == `PAGE_1);
      next_fb_page       = (fill_page_select == `PAGE_1);
    end else begin
      case (state)
        ST_IDLE: begin
        end
        ST_LOOKUP: begin
          next_fb_data = palette_color;
          next_state   = ST_FILL;
        end
        ST_FILL: begin
          next_fb_we   = page_ok;
          next_fb_addr = count;
          next_count   = count + `FB_AW'(1);
          if (count == LAST_WORD) begin
            next_state = ST_DRAIN;
          end
        end
        ST_DRAIN: begin
          evt.done_evt = 1'b1;
          next_state   = ST_IDLE;
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state         <= ST_IDLE;
      count         <= '0;
      auto_pending  <= 1'b1;
      page_ok       <= 1'b0;
      fb_page       <= 1'b0;
      fb_we         <= 1'b0;
      fb_addr       <= '0;
      fb_data       <= '0;
      palette_index <= '0;
      color_mode    <= '0;
    end else begin
      state         <= next_state;
      count         <= next_count;
      auto_pending  <= next_auto_pending;
      page_ok       <= next_page_ok;
      fb_page       <= next_fb_page;
      fb_we         <= next_fb_we;
      fb_addr       <= next_fb_addr;
      fb_data       <= next_fb_data;
      palette_index <= next_palette_index;
      color_mode    <= next_color_mode;
    end
  end

  // Busy follows the engine only, never the written data
  assign fill_busy   = (state != ST_IDLE);
  assign fill_done_n = evt.done_n;

  // ==========================================================================
  // Checks
  AST_CMD_SETS_BUSY: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_write |=> fill_busy && state == ST_LOOKUP)
    else $error("Command write did not start a fill");
  AST_ZERO_DATA_BUSY: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_write && pwdata[0] == 1'b0) |=> ##1 fill_busy)
    else $error("Busy followed written data");
  AST_AUTO_FILL: assert property (@(posedge pclk) disable iff (!presetn)
    auto_pending |=> fill_busy)
    else $error("No fill after reset release");
  AST_BUSY_READ: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && hit(paddr, `FILL_CMD_IDX))
      |=> prdata == {31'h0, $past(fill_busy)})
    else $error("Busy read value wrong");
  AST_BUSY_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_DRAIN && !start) |=> !fill_busy && evt.pulse_active ##1 !fill_done_n)
    else $error("Busy or done pulse wrong at fill end");
  AST_FILL_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_FILL && page_ok && !start)
      |=> fb_we && fb_addr == $past(count) && fb_data == $past(fb_data))
    else $error("Fill word not written");
  AST_INACTIVE_PAGE: assert property (@(posedge pclk) disable iff (!presetn)
    (start && fill_page_select[1]) |=> !fb_we [*3])
    else $error("Write to inactive page");
  AST_VALUE_REG: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_access && pstrb[0] && hit(paddr, `FILL_VALUE_IDX))
      |=> fill_value_reg == $past(pwdata[7:0]))
    else $error("Fill value not stored");

endmodule // frame_buffer_hard_fill
`default_nettype wire

// ### verilog/fill_defines.svh
`ifndef FILL_DEFINES_SVH
`define FILL_DEFINES_SVH

// ==========================================================================
// Register indices (byte address is four times the index)
`define PAGE_CTRL_IDX   17'h1fffd
`define FILL_VALUE_IDX  17'h1fffe
`define FILL_CMD_IDX    17'h1ffff
`define APB_ADDR_W      19

// ==========================================================================
// Field positions and reset values
`define BUSY_BIT        0
`define FILL_PAGE_HI    5
`define FILL_PAGE_LO    4
`define MODE_HI         7
`define MODE_LO         6
`define INDEX_HI        5
`define INDEX_LO        0
`define REG8_RESET      8'h00
`define PAGE_0          2'h0
`define PAGE_1          2'h1

// ==========================================================================
// Frame buffer geometry and timing
`define FB_AW           17
`define FB_WORDS_DEF    76800
`define COLOR_W         12
`define CLK_PERIOD_NS   40
`define DONE_PULSE_NS   66500
`define DONE_PULSE_CYC  (`DONE_PULSE_NS / `CLK_PERIOD_NS)
`define PULSE_CNT_W     11

`endif

// ### verilog/fill_pkg.sv
`default_nettype none
package fill_pkg;

  // Fill engine states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LOOKUP,
    ST_FILL,
    ST_DRAIN
  } fill_state_t;

endpackage
`default_nettype wire

// ### verilog/fill_evt_if.sv
`timescale 1ns/100ps
`default_nettype none
// Completion event from the engine to the pulse generator
interface fill_evt_if;
  logic done_evt;
  logic done_n;
  logic pulse_active;
  modport src (output done_evt, input done_n, input pulse_active);
  modport gen (input done_evt, output done_n, output pulse_active);
endinterface
`default_nettype wire

// ### verilog/fill_done_pulse.sv
`timescale 1ns/100ps
`default_nettype none
`include "fill_defines.svh"
module fill_done_pulse
  import fill_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  fill_evt_if.gen   evt
);

  logic                    active;
  logic                    next_active;
  logic [`PULSE_CNT_W-1:0] cnt;
  logic [`PULSE_CNT_W-1:0] next_cnt;
  localparam logic [`PULSE_CNT_W-1:0] LAST = `PULSE_CNT_W'(`DONE_PULSE_CYC - 1);

  // ==========================================================================
  // Low pulse timer, a new completion restarts it
  always_comb begin
    next_active = active;
    next_cnt    = cnt;
    if (evt.done_evt) begin
      next_active = 1'b1;
      next_cnt    = '0;
    end else if (active) begin
      if (cnt == LAST) begin
        next_active = 1'b0;
      end else begin
        next_cnt = cnt + `PULSE_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active <= 1'b0;
      cnt    <= '0;
    end else begin
      active <= next_active;
      cnt    <= next_cnt;
    end
  end

  assign evt.done_n       = ~active;
  assign evt.pulse_active = active;

  // ==========================================================================
  // Checks
  AST_PULSE_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (active && cnt != LAST) |=> !evt.done_n)
    else $error("Done pulse ended early");
  AST_PULSE_END: assert property (@(posedge pclk) disable iff (!presetn)
    (active && cnt == LAST && !evt.done_evt) |=> evt.done_n)
    else $error("Done pulse too long");

endmodule // fill_done_pulse
`default_nettype wire

// ### testbench/palette_model.sv
`timescale 1ns/100ps
`default_nettype none
`include "fill_defines.svh"
// ==========
// Palette and frame-buffer store beside the engine
module palette_model (
  input  wire logic                pclk,
  input  wire logic [5:0]          palette_index,
  output logic      [`COLOR_W-1:0] palette_color,
  input  wire logic                fb_we,
  input  wire logic [`FB_AW-1:0]   fb_addr,
  input  wire logic                fb_page,
  input  wire logic [`COLOR_W-1:0] fb_data
);
  logic [`COLOR_W-1:0] mem [2][16];
  int                  writes = 0;
  // Colour follows the index in the same cycle
  assign palette_color = {palette_index, palette_index ^ 6'h2a};
  // Store and count each word strobe
  always @(posedge pclk) begin
    if (fb_we === 1'b1) begin
      mem[fb_page][fb_addr[3:0]] <= fb_data;
      writes <= writes + 1;
    end
  end
endmodule // palette_model
`default_nettype wire

// ### testbench/frame_buffer_hard_fill_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "fill_defines.svh"
// ==========
// Bench for the fill engine
module frame_buffer_hard_fill_test;
  localparam logic [18:0] PAGE_A = {`PAGE_CTRL_IDX, 2'b00};
  localparam logic [18:0] VAL_A  = {`FILL_VALUE_IDX, 2'b00};
  localparam logic [18:0] CMD_A  = {`FILL_CMD_IDX, 2'b00};
  typedef struct packed {
    logic [1:0] page;
    logic [1:0] mode;
    logic [5:0] idx;
  } row_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [18:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0]  pstrb;
  logic [5:0]  palette_index;
  logic [11:0] palette_color, fb_data;
  logic        fb_we, fb_page, fill_busy, fill_done_n;
  logic [16:0] fb_addr;
  logic [1:0]  color_mode;
  logic [11:0] exp_color;
  int          bad_count, comparisons, base;
  row_t        rows [5] = '{'{2'h0, 2'h0, 6'h3f}, '{2'h1, 2'h3, 6'h00},
                            '{2'h2, 2'h1, 6'h15}, '{2'h3, 2'h2, 6'h2a},
                            '{2'h0, 2'h1, 6'h2a}};
  frame_buffer_hard_fill #(.FB_WORDS(16)) frame_buffer_hard_fill_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .palette_index(palette_index), .palette_color(palette_color),
    .fb_we(fb_we), .fb_addr(fb_addr), .fb_page(fb_page), .fb_data(fb_data),
    .color_mode(color_mode), .fill_busy(fill_busy), .fill_done_n(fill_done_n));
  palette_model palette_model_inst (
    .pclk(pclk), .palette_index(palette_index), .palette_color(palette_color),
    .fb_we(fb_we), .fb_addr(fb_addr), .fb_page(fb_page), .fb_data(fb_data));
  // ==========
  // Clock
  always #20 pclk = ~pclk;
  // ==========
  // Shared tasks
  task final_report();
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One APB transfer, result left in r and e
  task automatic apb(input logic w, input logic [18:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      bad_count++;
      final_report();
    end
  endtask
  // Poll busy, then time the completion pulse
  task automatic finish_fill();
    int n;
    n = 0;
    @(posedge pclk);
    while (fill_busy !== 1'b0 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    while (fill_done_n !== 1'b0 && n < 220) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 220) begin
      bad_count++;
      final_report();
    end
    n = 0;
    while (fill_done_n === 1'b0 && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    chk("done_low_cycles", n, 1662);
  endtask
  // ==========
  // Main sequence
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = '0; pwdata = '0; pstrb = 4'hf; bad_count = 0; comparisons = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("auto_busy", {31'h0, fill_busy}, 1);
    apb(1'b0, CMD_A, 0);
    chk("cmd_busy", r, 1);
    finish_fill();
    apb(1'b0, CMD_A, 0);
    chk("cmd_idle", r, 0);
    // Table of fills; write page kept equal to fill page
    foreach (rows[i]) begin
      apb(1'b1, PAGE_A, {26'h0, rows[i].page, 2'b00, rows[i].page});
      apb(1'b1, VAL_A, {24'h0, rows[i].mode, rows[i].idx});
      base = palette_model_inst.writes;
      apb(1'b1, CMD_A, 32'h5a);
      finish_fill();
      chk("mode", color_mode, rows[i].mode);
      chk("words", palette_model_inst.writes - base, rows[i].page < 2 ? 16 : 0);
      if (rows[i].page < 2) begin
        chk("page", fb_page, rows[i].page[0]);
        exp_color = {rows[i].idx, rows[i].idx ^ 6'h2a};
        for (int a = 0; a < 16; a++)
          chk("word", palette_model_inst.mem[rows[i].page[0]][a], exp_color);
      end
    end
    // Data with bit 0 set starts a fill but never sticks
    apb(1'b1, CMD_A, 32'hff);
    apb(1'b0, CMD_A, 0);
    chk("busy_on_write", r, 1);
    finish_fill();
    apb(1'b0, CMD_A, 0);
    chk("busy_not_stored", r, 0);
    // Write-only value register and an unmapped place
    apb(1'b0, VAL_A, 0);
    chk("value_reads_zero", r, 0);
    apb(1'b0, 19'h00010, 0);
    chk("unmapped_err", e, 1);
    apb(1'b1, 19'h00010, 0);
    @(posedge pclk);
    chk("no_fill_unmapped", fill_busy, 0);
    // Reset in mid-fill, then the automatic fill again
    apb(1'b1, CMD_A, 0);
    repeat (3) @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    @(posedge pclk);
    chk("rst_busy", fill_busy, 0);
    chk("rst_done", fill_done_n, 1);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("auto_busy2", fill_busy, 1);
    finish_fill();
    final_report();
  end
endmodule // frame_buffer_hard_fill_test
`default_nettype wire
